// ==== design/rcf_out_pkg.sv ====
`default_nettype none
package rcf_out_pkg;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_HB_A = 12'h008;
  localparam logic [11:0] IDX_HB_B = 12'h009;
  localparam logic [11:0] IDX_GL_A = 12'h00A;
  localparam logic [11:0] IDX_GL_B = 12'h012;
  localparam logic [11:0] IDX_GAIN_STAT = 12'h013;
  localparam logic [11:0] IDX_FOSC = 12'h0A4;

  // ==========================================================================
  // Widths and reset values.
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned FOSC_W = 11;
  localparam int unsigned REG_W = 8;
  localparam logic [10:0] FOSC_RST = 11'h000;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] GAIN_RST = 4'h0;
  localparam logic [3:0] GAIN_MAX = 4'hF;
  localparam logic [3:0] EXP_MAX = 4'hF;
  localparam logic [3:0] SCALE_UNITY = 4'h3;
  localparam logic [4:0] FULL_W = 5'h10;
  localparam logic [4:0] LINK_W = 5'h08;
  localparam logic [4:0] MANT_SMALL_W = 5'h08;
  localparam logic [4:0] MANT_LARGE_W = 5'h0C;

  // ==========================================================================
  // Filter output scale control fields.
  localparam int unsigned FOSC_SCALE_LSB = 0;
  localparam int unsigned FOSC_MODE_LSB = 4;
  localparam int unsigned FOSC_FIXED_EXP_BIT = 6;
  localparam int unsigned FOSC_SHARED_EXP_BIT = 7;
  localparam int unsigned FOSC_BANK_BIT = 8;
  localparam int unsigned FOSC_ALT_SRC_BIT = 9;
  localparam int unsigned FOSC_SELF_TEST_BIT = 10;

  typedef enum logic [1:0] {OUT_FIXED = 2'h0, OUT_FLOAT_SMALL = 2'h1, OUT_FLOAT_LARGE = 2'h2} out_mode_e;

  // ==========================================================================
  // Half-band control fields and coefficients.
  localparam int unsigned HB_EN_BIT = 0;
  localparam int unsigned HB_SEL_LSB = 1;
  localparam int unsigned HB_TAPS = 13;
  localparam int unsigned HB_NORM_SHIFT = 9;
  localparam logic signed [10:0] HB_COEF [HB_TAPS] = '{11'sh000, 11'sh00E, 11'sh000, -11'sh042, 11'sh000,
    11'sh135, 11'sh200, 11'sh135, 11'sh000, -11'sh042, 11'sh000, 11'sh00E, 11'sh000};

  typedef enum logic [1:0] {HB_IDLE = 2'h0, HB_DATA = 2'h1, HB_STUFF = 2'h3} hb_state_e;

  // ==========================================================================
  // Gain loop control fields.
  localparam int unsigned GL_BYPASS_BIT = 0;
  localparam int unsigned GL_WIDTH_LSB = 1;
  localparam int unsigned GL_MODE_BIT = 4;
  localparam int unsigned GL_LEVEL_LSB = 5;

endpackage

`default_nettype wire

// ==== design/rcf_output_halfband_agc_front.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Low four control bits hold the output scale value for fixed point.
// - Mode 00 fixed, 01 float 8+4, 1x float 12+4.
// - Fixed-point word width follows the parallel or link port choice.
// - Float words put the mantissa first, then the four-bit exponent.
// - Bit 6 clear picks exponent automatically; set uses the stored scale.
// - Output gain is scale minus three times about 6.02 dB.
// - Bit 7 set shares one overflow-safe exponent between I and Q.
// - Bit 8 pages coefficient writes; computation sees taps 127 and 128 contiguous.
// - Bit 9 takes input from channel 1 decimator; channel 1 from channel 0.
// - Bit 10 bypasses the coefficient filter and routes data to self test.
// - Two interpolating half-bands with 16-bit I and Q in and out.
// - Each half-band has its own enable register, A and B.
// - Interleaving still happens when interpolation is bypassed.
// - Half-band A takes {0..3},{0,1},{0}; B takes {2,3},{2}; interpolate by two.
// - Half-band is a 13-tap FIR with fixed symmetric coefficients.
// - Half-band and gain loop select independently; bypassed loop passes data on.
// - Two independent gain loops with 0 to 15 shifts, about 90 dB of gain range.
// - Gain loop compresses 23-bit input to 4-8, 10, 12 or 16 bits.
// - Loop bypass still clips to width and applies a constant gain.
// - Mode bit selects desired-level or desired-clipping mode; both use the one level field.
// - Level mode measures pre-clip path; clipping mode uses pre minus post.
// - Loop is power, error, loop filter and gain multiply, log-linear.
// - Mode bit zero selects desired output level mode, one clipping mode.
module rcf_output_halfband_agc_front
  import rcf_out_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0][19:0] dec_i,
  input wire logic [3:0][19:0] dec_q,
  input wire logic [3:0] dec_valid,
  output logic [3:0][19:0] cf_src_i,
  output logic [3:0][19:0] cf_src_q,
  output logic [3:0] cf_src_valid,
  output logic [3:0][19:0] self_test_i,
  output logic [3:0][19:0] self_test_q,
  output logic [3:0] self_test_valid,
  input wire logic [6:0] coef_wr_addr,
  input wire logic coef_wr_en,
  input wire logic [7:0] calc_tap,
  output logic [7:0] coef_mem_addr,
  output logic coef_mem_we,
  input wire logic [3:0] cf_start,
  input wire logic [3:0][23:0] cf_i,
  input wire logic [3:0][23:0] cf_q,
  input wire logic [3:0] cf_valid,
  input wire logic link_port_sel,
  output logic [3:0][15:0] ch_word_i,
  output logic [3:0][15:0] ch_word_q,
  output logic [3:0] ch_word_valid,
  output logic [1:0][15:0] out_i,
  output logic [1:0][15:0] out_q,
  output logic [1:0] out_valid
);

  // ==========================================================================
  // Helper functions.
  function automatic logic signed [15:0] sat_w(input logic signed [39:0] v, input logic [4:0] w);
    logic signed [39:0] hi;
    logic signed [39:0] lo;
    hi = (40'sh1 <<< (w - 5'h1)) - 40'sh1;
    lo = -hi - 40'sh1;
    if (v > hi)
      return hi[15:0];
    else if (v < lo)
      return lo[15:0];
    return v[15:0];
  endfunction

  function automatic logic [39:0] mag(input logic signed [39:0] v);
    return v[39] ? 40'(-v) : 40'(v);
  endfunction

  function automatic logic [5:0] msb_pos(input logic [39:0] v);
    logic [5:0] p;
    p = '0;
    for (int k = 0; k < 40; k++)
      if (v[k])
        p = 6'(k);
    return p;
  endfunction

  // Smallest exponent for which the sample fits the mantissa width.
  function automatic logic [3:0] auto_exp(input logic signed [23:0] x, input logic [4:0] mw);
    logic [3:0] e;
    logic signed [39:0] s;
    e = EXP_MAX;
    for (int k = 15; k >= 0; k--)
    begin
      s = 40'(x) >>> k;
      if (40'(sat_w(s, mw)) == s)
        e = 4'(k);
    end
    return e;
  endfunction

  function automatic logic [4:0] gl_width(input logic [2:0] sel);
    logic [4:0] t [8];
    t = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h10};
    return t[sel];
  endfunction

  function automatic logic [2:0] hb_count(input logic is_b, input logic [1:0] sel);
    if (is_b)
      return sel[0] ? 3'h2 : 3'h1;
    return (sel == 2'h0) ? 3'h1 : ((sel == 2'h1) ? 3'h2 : 3'h4);
  endfunction

  // Decoded register index: 0 none, 1..6 registers.
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    if (a[1:0] != 2'h0)
      return 3'h0;
    unique case (a[11:2])
      IDX_HB_A[9:0]: return 3'h1;
      IDX_HB_B[9:0]: return 3'h2;
      IDX_GL_A[9:0]: return 3'h3;
      IDX_GL_B[9:0]: return 3'h4;
      IDX_GAIN_STAT[9:0]: return 3'h5;
      IDX_FOSC[9:0]: return 3'h6;
      default: return 3'h0;
    endcase
  endfunction

  // ==========================================================================
  // APB slave and register file.
  logic [10:0] fosc_r, fosc_nxt;
  logic [7:0] hb_ctrl_r [2];
  logic [7:0] hb_ctrl_nxt [2];
  logic [7:0] gl_ctrl_r [2];
  logic [7:0] gl_ctrl_nxt [2];
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [3:0] gain_of [2];
  logic [2:0] sel_now;

  always_comb
  begin
    sel_now = reg_sel(paddr);
    fosc_nxt = fosc_r;
    hb_ctrl_nxt = hb_ctrl_r;
    gl_ctrl_nxt = gl_ctrl_r;
    prdata_nxt = prdata;
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && (sel_now == 3'h0);
    if (psel && !penable)
      unique case (sel_now)
        3'h1: prdata_nxt = 32'(hb_ctrl_r[0]);
        3'h2: prdata_nxt = 32'(hb_ctrl_r[1]);
        3'h3: prdata_nxt = 32'(gl_ctrl_r[0]);
        3'h4: prdata_nxt = 32'(gl_ctrl_r[1]);
        3'h5: prdata_nxt = 32'({gain_of[1], gain_of[0]});
        3'h6: prdata_nxt = 32'(fosc_r);
        default: prdata_nxt = 32'h0000_0000;
      endcase
    if (psel && penable && pready && pwrite)
      unique case (sel_now)
        3'h1: hb_ctrl_nxt[0] = pwdata[7:0];
        3'h2: hb_ctrl_nxt[1] = pwdata[7:0];
        3'h3: gl_ctrl_nxt[0] = pwdata[7:0];
        3'h4: gl_ctrl_nxt[1] = pwdata[7:0];
        3'h6: fosc_nxt = pwdata[10:0];
        default: fosc_nxt = fosc_r;
      endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fosc_r <= FOSC_RST;
      hb_ctrl_r <= '{CTRL_RST, CTRL_RST};
      gl_ctrl_r <= '{CTRL_RST, CTRL_RST};
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      fosc_r <= fosc_nxt;
      hb_ctrl_r <= hb_ctrl_nxt;
      gl_ctrl_r <= gl_ctrl_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ==========================================================================
  // Coefficient memory addressing: paged writes, flat computation address.
  logic [7:0] cma_nxt;
  logic cmw_nxt;

  always_comb
  begin
    cmw_nxt = coef_wr_en;
    cma_nxt = coef_wr_en ? {fosc_r[FOSC_BANK_BIT], coef_wr_addr} : calc_tap;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      coef_mem_addr <= 8'h00;
      coef_mem_we <= 1'b0;
    end
    else
    begin
      coef_mem_addr <= cma_nxt;
      coef_mem_we <= cmw_nxt;
    end
  end

  // ==========================================================================
  // Per-channel source selection and output formatting.
  logic signed [15:0] fix_i [NUM_CH];
  logic signed [15:0] fix_q [NUM_CH];
  logic fix_v [NUM_CH];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : ch
      localparam int unsigned ALT = (g == 1) ? 0 : 1;
      logic [19:0] si_r, si_nxt, sq_r, sq_nxt, ti_r, ti_nxt, tq_r, tq_nxt;
      logic sv_r, sv_nxt, tv_r, tv_nxt;
      logic [10:0] cu_r, cu_nxt;
      logic [15:0] wi_r, wi_nxt, wq_r, wq_nxt;
      logic signed [15:0] fi_r, fi_nxt, fq_r, fq_nxt;
      logic wv_r, wv_nxt;
      logic [3:0] ei, eq, eu;
      logic [4:0] mw, fw;
      logic signed [15:0] mi, mq;
      logic [1:0] md;

      always_comb
      begin
        si_nxt = fosc_r[FOSC_ALT_SRC_BIT] ? dec_i[ALT] : dec_i[g];
        sq_nxt = fosc_r[FOSC_ALT_SRC_BIT] ? dec_q[ALT] : dec_q[g];
        sv_nxt = dec_valid[g] && !fosc_r[FOSC_SELF_TEST_BIT];
        ti_nxt = fosc_r[FOSC_SELF_TEST_BIT] ? si_nxt : 20'h00000;
        tq_nxt = fosc_r[FOSC_SELF_TEST_BIT] ? sq_nxt : 20'h00000;
        tv_nxt = dec_valid[g] && fosc_r[FOSC_SELF_TEST_BIT];
        cu_nxt = cf_start[g] ? fosc_r : cu_r;
        md = cu_r[FOSC_MODE_LSB +: 2];
        mw = md[1] ? MANT_LARGE_W : MANT_SMALL_W;
        fw = link_port_sel ? LINK_W : FULL_W;
        ei = auto_exp(cf_i[g], mw);
        eq = auto_exp(cf_q[g], mw);
        if (cu_r[FOSC_FIXED_EXP_BIT])
        begin
          ei = EXP_MAX - cu_r[FOSC_SCALE_LSB +: 4];
          eq = ei;
        end
        eu = (ei > eq) ? ei : eq;
        if (cu_r[FOSC_SHARED_EXP_BIT])
        begin
          ei = eu;
          eq = eu;
        end
        mi = sat_w(40'(signed'(cf_i[g])) >>> ei, mw);
        mq = sat_w(40'(signed'(cf_q[g])) >>> eq, mw);
        fi_nxt = sat_w((40'(signed'(cf_i[g])) <<< cu_r[FOSC_SCALE_LSB +: 4]) >>> SCALE_UNITY, FULL_W);
        fq_nxt = sat_w((40'(signed'(cf_q[g])) <<< cu_r[FOSC_SCALE_LSB +: 4]) >>> SCALE_UNITY, FULL_W);
        wi_nxt = 16'(sat_w(40'(fi_nxt), fw) <<< (FULL_W - fw));
        wq_nxt = 16'(sat_w(40'(fq_nxt), fw) <<< (FULL_W - fw));
        if (md[1])
        begin
          wi_nxt = {mi[11:0], ei};
          wq_nxt = {mq[11:0], eq};
        end
        else if (md == OUT_FLOAT_SMALL)
        begin
          wi_nxt = {mi[7:0], ei, 4'h0};
          wq_nxt = {mq[7:0], eq, 4'h0};
        end
        wv_nxt = cf_valid[g];
        if (!cf_valid[g])
        begin
          wi_nxt = wi_r;
          wq_nxt = wq_r;
          fi_nxt = fi_r;
          fq_nxt = fq_r;
        end
      end

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          {si_r, sq_r, ti_r, tq_r} <= '0;
          {sv_r, tv_r, wv_r} <= '0;
          cu_r <= FOSC_RST;
          {wi_r, wq_r, fi_r, fq_r} <= '0;
        end
        else
        begin
          {si_r, sq_r, ti_r, tq_r} <= {si_nxt, sq_nxt, ti_nxt, tq_nxt};
          {sv_r, tv_r, wv_r} <= {sv_nxt, tv_nxt, wv_nxt};
          cu_r <= cu_nxt;
          {wi_r, wq_r, fi_r, fq_r} <= {wi_nxt, wq_nxt, fi_nxt, fq_nxt};
        end
      end

      assign cf_src_i[g] = si_r;
      assign cf_src_q[g] = sq_r;
      assign cf_src_valid[g] = sv_r;
      assign self_test_i[g] = ti_r;
      assign self_test_q[g] = tq_r;
      assign self_test_valid[g] = tv_r;
      assign ch_word_i[g] = wi_r;
      assign ch_word_q[g] = wq_r;
      assign ch_word_valid[g] = wv_r;
      assign fix_i[g] = fi_r;
      assign fix_q[g] = fq_r;
      assign fix_v[g] = wv_r;
    end
  endgenerate

  // ==========================================================================
  // Interleaving half-band interpolators and gain loops.
  genvar h;
  generate
    for (h = 0; h < 2; h++)
    begin : hb
      localparam int unsigned BASE = 2 * h;
      hb_state_e st_r, st_nxt;
      logic [1:0] idx_r, idx_nxt;
      logic signed [15:0] tpi_r [HB_TAPS];
      logic signed [15:0] tpi_nxt [HB_TAPS];
      logic signed [15:0] tpq_r [HB_TAPS];
      logic signed [15:0] tpq_nxt [HB_TAPS];
      logic push_r, push_nxt, last, interp;
      logic signed [15:0] hi_r, hi_nxt, hq_r, hq_nxt, pi, pq;
      logic hv_r, hv_nxt;
      logic signed [27:0] acc_i, acc_q;
      logic [2:0] cnt;

      always_comb
      begin
        interp = hb_ctrl_r[h][HB_EN_BIT];
        cnt = hb_count(h == 1, hb_ctrl_r[h][HB_SEL_LSB +: 2]);
        last = (3'(idx_r) + 3'h1) >= cnt;
        st_nxt = st_r;
        idx_nxt = idx_r;
        push_nxt = 1'b0;
        pi = fix_i[BASE + idx_r];
        pq = fix_q[BASE + idx_r];
        unique case (st_r)
          HB_IDLE:
            if (fix_v[BASE])
            begin
              st_nxt = HB_DATA;
              idx_nxt = 2'h0;
            end
          HB_DATA:
          begin
            push_nxt = 1'b1;
            st_nxt = interp ? HB_STUFF : (last ? HB_IDLE : HB_DATA);
            idx_nxt = (interp || last) ? idx_r : idx_r + 2'h1;
          end
          HB_STUFF:
          begin
            push_nxt = 1'b1;
            pi = 16'sh0000;
            pq = 16'sh0000;
            st_nxt = last ? HB_IDLE : HB_DATA;
            idx_nxt = last ? idx_r : idx_r + 2'h1;
          end
          default: st_nxt = HB_IDLE;
        endcase
        tpi_nxt = tpi_r;
        tpq_nxt = tpq_r;
        if (push_nxt)
        begin
          for (int k = HB_TAPS - 1; k > 0; k--)
          begin
            tpi_nxt[k] = tpi_r[k - 1];
            tpq_nxt[k] = tpq_r[k - 1];
          end
          tpi_nxt[0] = pi;
          tpq_nxt[0] = pq;
        end
        acc_i = '0;
        acc_q = '0;
        for (int k = 0; k < HB_TAPS; k++)
        begin
          acc_i = acc_i + 28'(tpi_r[k] * HB_COEF[k]);
          acc_q = acc_q + 28'(tpq_r[k] * HB_COEF[k]);
        end
        hi_nxt = interp ? sat_w(40'(acc_i) >>> HB_NORM_SHIFT, FULL_W) : tpi_r[0];
        hq_nxt = interp ? sat_w(40'(acc_q) >>> HB_NORM_SHIFT, FULL_W) : tpq_r[0];
        hv_nxt = push_r;
      end

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          st_r <= HB_IDLE;
          idx_r <= 2'h0;
          push_r <= 1'b0;
          tpi_r <= '{default: 16'sh0000};
          tpq_r <= '{default: 16'sh0000};
          {hi_r, hq_r, hv_r} <= '0;
        end
        else
        begin
          st_r <= st_nxt;
          idx_r <= idx_nxt;
          push_r <= push_nxt;
          tpi_r <= tpi_nxt;
          tpq_r <= tpq_nxt;
          {hi_r, hq_r, hv_r} <= {hi_nxt, hq_nxt, hv_nxt};
        end
      end

      // Gain loop: 23-bit sign-extended input, shift gain, clip, adapt.
      logic [3:0] gn_r, gn_nxt, gn_use;
      logic [15:0] oi_r, oi_nxt, oq_r, oq_nxt;
      logic ov_r, ov_nxt;
      logic [4:0] w;
      logic signed [39:0] pre_i, pre_q, di, dq;
      logic signed [15:0] po_i, po_q;
      logic [5:0] meas, tgt;
      logic [2:0] lvl;

      always_comb
      begin
        w = gl_width(gl_ctrl_r[h][GL_WIDTH_LSB +: 3]);
        lvl = gl_ctrl_r[h][GL_LEVEL_LSB +: 3];
        gn_use = gl_ctrl_r[h][GL_BYPASS_BIT] ? 4'(lvl) : gn_r;
        pre_i = (40'(23'(hi_r)) <<< gn_use) >>> (FULL_W - w);
        pre_q = (40'(23'(hq_r)) <<< gn_use) >>> (FULL_W - w);
        po_i = sat_w(pre_i, w);
        po_q = sat_w(pre_q, w);
        di = pre_i - 40'(po_i);
        dq = pre_q - 40'(po_q);
        if (gl_ctrl_r[h][GL_MODE_BIT])
        begin
          meas = msb_pos(mag(di) | mag(dq));
          tgt = 6'(lvl);
        end
        else
        begin
          meas = msb_pos(mag(pre_i) | mag(pre_q));
          tgt = 6'(w) - 6'(lvl) - 6'h1;
        end
        gn_nxt = gn_r;
        if (hv_r && !gl_ctrl_r[h][GL_BYPASS_BIT])
        begin
          if (meas < tgt && gn_r != GAIN_MAX)
            gn_nxt = gn_r + 4'h1;
          else if (meas > tgt && gn_r != GAIN_RST)
            gn_nxt = gn_r - 4'h1;
        end
        oi_nxt = hv_r ? 16'(po_i <<< (FULL_W - w)) : oi_r;
        oq_nxt = hv_r ? 16'(po_q <<< (FULL_W - w)) : oq_r;
        ov_nxt = hv_r;
      end

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          gn_r <= GAIN_RST;
          {oi_r, oq_r, ov_r} <= '0;
        end
        else
        begin
          gn_r <= gn_nxt;
          {oi_r, oq_r, ov_r} <= {oi_nxt, oq_nxt, ov_nxt};
        end
      end

      assign gain_of[h] = gn_r;
      assign out_i[h] = oi_r;
      assign out_q[h] = oq_r;
      assign out_valid[h] = ov_r;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== verif/rcf_out_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level properties of the output front.
module rcf_out_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [3:0][19:0] dec_i,
  input wire logic [3:0] dec_valid,
  input wire logic [3:0][19:0] cf_src_i,
  input wire logic [3:0] cf_src_valid,
  input wire logic [3:0] self_test_valid,
  input wire logic [6:0] coef_wr_addr,
  input wire logic coef_wr_en,
  input wire logic [7:0] calc_tap,
  input wire logic [7:0] coef_mem_addr,
  input wire logic coef_mem_we,
  input wire logic [3:0] cf_valid,
  input wire logic [3:0][15:0] ch_word_i,
  input wire logic [3:0] ch_word_valid,
  input wire logic [1:0] out_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  sequence s_hb_out; ##[2:6] out_valid[0]; endsequence
  property p_apb_answer; s_setup |=> s_access; endproperty
  property p_pready_pulse; pready |=> !pready; endproperty
  property p_src_route; dec_valid[0] |=> cf_src_valid[0] ^ self_test_valid[0]; endproperty
  property p_src_data;
    cf_src_valid[0] |-> cf_src_i[0] == $past(dec_i[0]) || cf_src_i[0] == $past(dec_i[1]);
  endproperty
  property p_coef_write; coef_wr_en |=> coef_mem_we && coef_mem_addr[6:0] == $past(coef_wr_addr); endproperty
  property p_coef_calc; !coef_wr_en |=> !coef_mem_we && coef_mem_addr == $past(calc_tap); endproperty
  property p_word_timing; cf_valid[0] |=> ch_word_valid[0]; endproperty
  property p_word_hold; !ch_word_valid[0] |-> $stable(ch_word_i[0]); endproperty
  property p_hb_a; ch_word_valid[0] |-> s_hb_out; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no access answer");
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");
  a_src_route: assert property (p_src_route) else $error("source route");
  a_src_data: assert property (p_src_data) else $error("source data");
  a_coef_write: assert property (p_coef_write) else $error("coef write");
  a_coef_calc: assert property (p_coef_calc) else $error("coef calc");
  a_word_timing: assert property (p_word_timing) else $error("word late");
  a_word_hold: assert property (p_word_hold) else $error("word moved");
  a_hb_a: assert property (p_hb_a) else $error("half-band silent");
endmodule

bind rcf_output_halfband_agc_front rcf_out_props rcf_out_props_inst (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pready(pready), .dec_i(dec_i), .dec_valid(dec_valid), .cf_src_i(cf_src_i),
  .cf_src_valid(cf_src_valid), .self_test_valid(self_test_valid), .coef_wr_addr(coef_wr_addr),
  .coef_wr_en(coef_wr_en), .calc_tap(calc_tap), .coef_mem_addr(coef_mem_addr), .coef_mem_we(coef_mem_we),
  .cf_valid(cf_valid), .ch_word_i(ch_word_i), .ch_word_valid(ch_word_valid), .out_valid(out_valid));
`default_nettype wire

// ==== verif/rake_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Receiver sink: counts gain loop samples and keeps the last loop A sample.
module rake_sink (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] out_valid,
  input wire logic [1:0][15:0] out_i,
  input wire logic [1:0][15:0] out_q,
  output logic [15:0] cnt_a,
  output logic [15:0] cnt_b,
  output logic [31:0] last_a
);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
      last_a <= 32'h00000000;
    end
    else
    begin
      cnt_a <= cnt_a + 16'(out_valid[0]);
      cnt_b <= cnt_b + 16'(out_valid[1]);
      if (out_valid[0])
        last_a <= {out_i[0], out_q[0]};
    end
  end
endmodule
`default_nettype wire

// ==== verif/rcf_output_halfband_agc_front_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcf_output_halfband_agc_front_test;
  import rcf_out_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, coef_wr_en = 0, lps = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, ex;
  logic [3:0][19:0] dec_i = '0, dec_q = '0;
  logic [3:0][23:0] cf_i = '0, cf_q = '0;
  logic [3:0] dec_valid = 0, cf_start = 0, cf_valid = 0, cwv;
  logic [6:0] coef_wr_addr = 0;
  logic [7:0] calc_tap = 0, cma;
  logic [3:0][15:0] cwi, cwq;
  logic [1:0][15:0] out_i, out_q;
  logic [1:0] out_valid;
  logic [15:0] ca, cb, ca0, cb0;
  logic [31:0] la;
  logic e, cmw;
  logic [31:0] exp_q[$];
  int mismatches = 0, n_checks = 0, x, s;
  logic [11:0] ra[5] = '{12'h020, 12'h024, 12'h028, 12'h048, 12'h290};
  logic [31:0] rm[5] = '{32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'h7FF};
  logic [10:0] tf[7] = '{11'h013, 11'h023, 11'h033, 11'h053, 11'h093, 11'h203, 11'h403};
  logic [23:0] ti[7] = '{24'd1000, 24'd1000, 24'd1000, 24'd8192, 24'd1000, 24'd5, 24'd5};
  logic [23:0] tq[7] = '{24'd100, 24'd100, 24'd100, 24'd4096, 24'd10, 24'd6, 24'd6};
  logic [31:0] te[7] = '{32'h7D306400, 32'h3E800640, 32'h3E800640, 32'h02C001C0, 32'h7D300130, 32'h00050006,
    32'h00050006};

  rcf_output_halfband_agc_front rcf_output_halfband_agc_front_inst (.clk(clk), .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dec_i(dec_i), .dec_q(dec_q), .dec_valid(dec_valid), .cf_src_i(), .cf_src_q(),
    .cf_src_valid(), .self_test_i(), .self_test_q(), .self_test_valid(), .coef_wr_addr(coef_wr_addr),
    .coef_wr_en(coef_wr_en), .calc_tap(calc_tap), .coef_mem_addr(cma), .coef_mem_we(cmw), .cf_start(cf_start),
    .cf_i(cf_i), .cf_q(cf_q), .cf_valid(cf_valid), .link_port_sel(lps), .ch_word_i(cwi), .ch_word_q(cwq),
    .ch_word_valid(cwv), .out_i(out_i), .out_q(out_q), .out_valid(out_valid));
  rake_sink rake_sink_inst (.clk(clk), .rst_b(rst_b), .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
    .cnt_a(ca), .cnt_b(cb), .last_a(la));

  always #5 clk = ~clk;

  task give_verdict;
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] w);
    n_checks++;
    if (g !== w)
    begin
      $display("BAD %0t got %h expected %h", $time, g, w);
      mismatches++;
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task send(input logic [23:0] xi, input logic [23:0] xq, input logic [31:0] w);
    @(posedge clk);
    cf_start[0] <= 1;
    @(posedge clk);
    cf_start[0] <= 0;
    cf_valid[0] <= 1;
    cf_i[0] <= xi;
    cf_q[0] <= xq;
    dec_valid <= 4'hF;
    dec_i[0] <= 20'($urandom);
    dec_i[1] <= 20'($urandom);
    coef_wr_en <= 1'($urandom);
    coef_wr_addr <= 7'($urandom);
    calc_tap <= 8'($urandom);
    exp_q.push_back(w);
    @(posedge clk);
    cf_valid[0] <= 0;
    dec_valid <= 4'h0;
    repeat (8) @(posedge clk);
  endtask

  always @(posedge clk)
    if (cwv[0] === 1'b1)
    begin
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hXXXXXXXX;
      chk({cwi[0], cwq[0]}, ex);
    end

  initial
  begin
    #300us;
    mismatches++;
    give_verdict;
  end

  initial
  begin
    void'($urandom(25631));
    repeat (8) @(posedge clk);
    rst_b <= 1;
    foreach (ra[k])
    begin
      apb(0, ra[k], 0);
      chk(r, 0);
      apb(1, ra[k], $urandom);
      ex = pwdata & rm[k];
      apb(0, ra[k], 0);
      chk(r, ex);
    end
    apb(1, 12'h004, 32'hFFFFFFFF);
    chk({31'h0, e}, 1);
    apb(0, 12'h021, 0);
    chk({r[30:0], e}, 1);
    for (s = 0; s < 6; s++)
    begin
      apb(1, 12'h290, s);
      repeat (3)
      begin
        x = int'($urandom_range(1000)) - 500;
        send(24'(x), 24'(-x), {16'(s >= 3 ? x <<< (s - 3) : x >>> (3 - s)),
          16'(s >= 3 ? -x <<< (s - 3) : -x >>> (3 - s))});
      end
    end
    apb(1, 12'h290, 32'h003);
    lps <= 1;
    x = int'($urandom_range(200)) - 100;
    send(24'(x), 24'(7), {8'(x), 8'h00, 16'h0700});
    lps <= 0;
    foreach (tf[k])
    begin
      apb(1, 12'h290, {21'h0, tf[k]});
      send(ti[k], tq[k], te[k]);
    end
    apb(1, 12'h290, 32'h003);
    apb(1, 12'h028, 32'h0F);
    for (s = 1; s >= 0; s--)
    begin
      apb(1, 12'h020, s);
      ca0 = ca;
      cb0 = cb;
      repeat (4) send(24'd64, 24'd32, 32'h00400020);
      repeat (10) @(posedge clk);
      chk(32'(ca - ca0), s ? 8 : 4);
      chk(32'(cb - cb0), 0);
    end
    chk(la, 32'h00400020);
    chk(exp_q.size(), 0);
    give_verdict;
  end
endmodule
`default_nettype wire
